// [adc_ctrl_pkg.sv]
// shared constants and types for the converter control and serial readout
package adc_ctrl_pkg;

  // core clock rate
  localparam int CLK_MHZ      = 250;

  // documented times in ns
  localparam int WAKE_NS      = 6000;
  localparam int CONV_NS      = 8000;
  localparam int LSB_HOLD_NS  = 10;

  // cycle counts derived from the times; the lsb hold is a least time, so it rounds up
  localparam int WAKE_CYC     = (WAKE_NS * CLK_MHZ) / 1000;
  localparam int CONV_CYC     = (CONV_NS * CLK_MHZ) / 1000;
  localparam int LSB_HOLD_CYC = (LSB_HOLD_NS * CLK_MHZ + 999) / 1000;

  // result and frame layout
  localparam int RESULT_W     = 12;
  localparam int LEAD_ZEROS   = 4;
  localparam int FRAME_LEN    = 16;
  localparam int CNT_W        = 5;
  localparam int HOLD_W       = 3;
  localparam int TIMER_W      = 12;

  // reset values
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  typedef enum logic [2:0] {
    ST_TRACK,
    ST_CONVERT,
    ST_SLEEP,
    ST_WAKE,
    ST_ARMED
  } conv_state_t;

endpackage : adc_ctrl_pkg

// [pin_sync.sv]
// two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);

  logic meta_q;
  logic meta_d;
  logic level_q;
  logic level_d;

  always_comb begin
    meta_d  = pin;
    level_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q  <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule : pin_sync

// [interval_timer.sv]
// down-counting interval timer, one-cycle done pulse
`timescale 1ns/1ps
module interval_timer #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         done_q;
  logic         done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (load) begin
      cnt_d = load_value;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule : interval_timer

// [adc_conv_readout.sv]
// conversion sequencing and three-wire serial result readout
//
// Contract
// R1: convert_start_n low at conversion end picks auto-sleep, high picks high-sampling.
// R2: in auto-sleep, sleep is entered as soon as busy falls.
// R3: in auto-sleep, convert_start_n rising wakes; hold follows 6 us later.
// R4: with convert_start_n already low, busy falls 8 us after hold.
// R5: a high pulse longer than wake-up moves hold to the falling edge.
// R6: the stored result reads out while asleep, sixteen shift clocks.
// R7: the master ends each read 400 ns before the next start falling edge.
// R8: output changes on shift clock falling edges, valid across both following edges.
// R9: the first leading zero appears on the first rising shift clock edge.
// R10: frame is four zeros then twelve result bits, msb first.
// R11: on the sixteenth falling edge the lsb is held briefly, then tri-stated.
// R12: the master keeps the shift clock low between reads.
// R13: extra clocks restart the frame; the output then stays driven.
// R14: an edge counter picks which frame bit drives the output.
// R15: start falling edge resets counter and shifter, only with shift clock low.
// R16: the master holds the shift clock low when it drives start low.
// R17: the master never drops start during a read.
// R18: the shift clock may pause low mid-read; output resumes at next bit.
// R19: the master keeps the shift clock at or below 10 MHz; the bench master model runs it at a 64 ns period (about 15.6 MHz).
// R20: the device is always the serial slave; the master makes the clock.
// R21: the master may gate the shift clock with a high select.
// R22: the master watches busy before starting a read.
// R23: in high-sampling, start falling edge holds, raises busy, busy falls in 8 us.
// R24: when busy falls the track/hold returns to tracking.
// R25: the result is straight unsigned binary, one step is full scale over 4096.
// R26: the last result stays in the output register until the next conversion ends.
`timescale 1ns/1ps
module adc_conv_readout
  import adc_ctrl_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              convert_start_n,
  input  wire logic                              shift_clk,
  input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] sample_code,
  output logic                                   busy,
  output logic                                   hold,
  output logic                                   asleep,
  output logic                                   serial_result_out,
  output logic                                   serial_result_oe
);

  // pin synchronisers and edge detection
  logic start_s;
  logic sclk_s;
  logic start_prev_q;
  logic start_prev_d;
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic start_fall;
  logic start_rise;
  logic sclk_fall;
  logic sclk_rise;

  pin_sync #(
    .RST_VAL (1'b1)
  ) u_start_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (convert_start_n),
    .level (start_s)
  );

  pin_sync #(
    .RST_VAL (1'b0)
  ) u_sclk_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (shift_clk),                      // [R20]
    .level (sclk_s)
  );

  always_comb begin
    start_prev_d = start_s;
    sclk_prev_d  = sclk_s;
    start_fall   = start_prev_q & ~start_s;
    start_rise   = ~start_prev_q & start_s;
    sclk_fall    = sclk_prev_q & ~sclk_s;
    sclk_rise    = ~sclk_prev_q & sclk_s;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_prev_q <= 1'b1;
      sclk_prev_q  <= 1'b0;
    end else begin
      start_prev_q <= start_prev_d;
      sclk_prev_q  <= sclk_prev_d;
    end
  end

  // one timer serves both the wake-up wait and the conversion time,
  // since the two never overlap
  logic               tmr_load;
  logic [TIMER_W-1:0] tmr_value;
  logic               tmr_done;

  interval_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk        (clk),
    .rst        (rst),
    .load       (tmr_load),
    .load_value (tmr_value),
    .done       (tmr_done)
  );

  // conversion sequencer
  conv_state_t           state_q;
  conv_state_t           state_d;
  logic                  busy_q;
  logic                  busy_d;
  logic                  hold_q;
  logic                  hold_d;
  logic                  asleep_q;
  logic                  asleep_d;
  logic [RESULT_W-1:0]   result_q;
  logic [RESULT_W-1:0]   result_d;

  always_comb begin
    state_d   = state_q;
    busy_d    = busy_q;
    hold_d    = hold_q;
    asleep_d  = asleep_q;
    result_d  = result_q;
    tmr_load  = 1'b0;
    tmr_value = TIMER_W'(CONV_CYC);
    case (state_q)
      ST_TRACK: begin
        if (start_fall) begin
          state_d  = ST_CONVERT;                  // [R23]
          hold_d   = 1'b1;
          busy_d   = 1'b1;
          tmr_load = 1'b1;
        end
      end
      ST_CONVERT: begin
        // start edges during conversion are ignored
        if (tmr_done) begin
          result_d = sample_code;                 // [R25] [R26]
          busy_d   = 1'b0;
          hold_d   = 1'b0;                        // [R24]
          if (!start_s) begin
            state_d  = ST_SLEEP;                  // [R1] [R2]
            asleep_d = 1'b1;
          end else begin
            state_d  = ST_TRACK;                  // [R1]
          end
        end
      end
      ST_SLEEP: begin
        if (start_rise) begin
          state_d   = ST_WAKE;                    // [R3]
          asleep_d  = 1'b0;
          busy_d    = 1'b1;
          tmr_load  = 1'b1;
          tmr_value = TIMER_W'(WAKE_CYC);
        end
      end
      ST_WAKE: begin
        if (tmr_done) begin
          if (!start_s) begin
            state_d  = ST_CONVERT;                // [R3] [R4]
            hold_d   = 1'b1;
            tmr_load = 1'b1;
          end else begin
            state_d  = ST_ARMED;                  // [R5]
          end
        end
      end
      ST_ARMED: begin
        // start pulse outlasted the wake-up: hold waits for the falling edge
        if (start_fall) begin
          state_d  = ST_CONVERT;                  // [R5]
          hold_d   = 1'b1;
          tmr_load = 1'b1;
        end
      end
      default: begin
        state_d = ST_TRACK;
        busy_d  = 1'b0;
        hold_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= ST_TRACK;
      busy_q   <= 1'b0;
      hold_q   <= 1'b0;
      asleep_q <= 1'b0;
      result_q <= RESULT_RST;
    end else begin
      state_q  <= state_d;
      busy_q   <= busy_d;
      hold_q   <= hold_d;
      asleep_q <= asleep_d;
      result_q <= result_d;
    end
  end

  // frame bit k: four leading zeros, then result msb down to lsb
  function automatic logic frame_bit(input logic [RESULT_W-1:0] word,
                                     input logic [CNT_W-1:0]    idx);
    logic [CNT_W-1:0] pos;
    pos = CNT_W'(FRAME_LEN - 1) - idx;
    if (idx < CNT_W'(LEAD_ZEROS)) begin
      frame_bit = 1'b0;
    end else begin
      frame_bit = word[pos[3:0]];
    end
  endfunction : frame_bit

  // serial readout; runs regardless of sleep so results read while asleep
  logic [CNT_W-1:0]  fall_cnt_q;
  logic [CNT_W-1:0]  fall_cnt_d;
  logic              done_q;
  logic              done_d;
  logic              overrun_q;
  logic              overrun_d;
  logic              sdo_q;
  logic              sdo_d;
  logic              oe_q;
  logic              oe_d;
  logic [HOLD_W-1:0] tail_q;
  logic [HOLD_W-1:0] tail_d;

  always_comb begin
    fall_cnt_d = fall_cnt_q;
    done_d     = done_q;
    overrun_d  = overrun_q;
    sdo_d      = sdo_q;
    oe_d       = oe_q;
    tail_d     = tail_q;
    if (tail_q != '0) begin
      tail_d = tail_q - 1'b1;
      if (tail_q == HOLD_W'(1)) begin
        oe_d = 1'b0;                              // [R11]
      end
    end
    if (start_fall && !sclk_s) begin
      fall_cnt_d = '0;                            // [R15]
      done_d     = 1'b0;
      overrun_d  = 1'b0;
      sdo_d      = 1'b0;
      oe_d       = 1'b0;
      tail_d     = '0;
    end else if (sclk_rise) begin
      if (fall_cnt_q == '0 && (!oe_q || done_q)) begin
        // first rising edge, or one past a finished frame: restart at bit 0
        sdo_d  = frame_bit(result_q, '0);         // [R9] [R10]
        oe_d   = 1'b1;
        tail_d = '0;
        if (done_q) begin
          overrun_d = 1'b1;                       // [R13]
        end
        done_d = 1'b0;
      end
    end else if (sclk_fall && oe_q) begin
      if (fall_cnt_q == CNT_W'(FRAME_LEN - 1)) begin
        // sixteenth falling edge: lsb lingers, then the line lets go, unless an overrun restarted the frame
        fall_cnt_d = '0;
        done_d     = 1'b1;
        if (!overrun_q) begin
          tail_d = HOLD_W'(LSB_HOLD_CYC);         // [R11]
        end
      end else begin
        fall_cnt_d = fall_cnt_q + 1'b1;           // [R14] [R18]
        sdo_d      = frame_bit(result_q, fall_cnt_q + 1'b1); // [R8] [R10] [R6]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fall_cnt_q <= '0;
      done_q     <= 1'b0;
      overrun_q  <= 1'b0;
      sdo_q      <= 1'b0;
      oe_q       <= 1'b0;
      tail_q     <= '0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
      done_q     <= done_d;
      overrun_q  <= overrun_d;
      sdo_q      <= sdo_d;
      oe_q       <= oe_d;
      tail_q     <= tail_d;
    end
  end

  assign busy              = busy_q;
  assign hold              = hold_q;
  assign asleep            = asleep_q;
  assign serial_result_out = sdo_q;
  assign serial_result_oe  = oe_q;

endmodule : adc_conv_readout

// [adc_conv_readout_monitor.sv]
// assertion checker for the conversion control and serial readout
`timescale 1ns/1ps
module adc_conv_readout_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic shift_clk,
  input wire logic busy,
  input wire logic hold,
  input wire logic asleep,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] hold_cnt_q;
  logic [11:0] hold_cnt_d;
  always_comb hold_cnt_d = hold ? hold_cnt_q + 12'h001 : 12'h000;
  always_ff @(posedge clk) hold_cnt_q <= rst ? 12'h000 : hold_cnt_d;
  // wake-up keeps busy up with the track/hold still tracking
  sequence s_wake;
    (busy && !hold) [*8];
  endsequence
  property p_hold_busy; hold |-> busy; endproperty
  property p_conv_len;
    $fell(hold) |-> $past(hold_cnt_q) >= 12'h7cb && $past(hold_cnt_q) <= 12'h7d5;
  endproperty
  property p_track; $fell(busy) |-> !hold; endproperty
  property p_sleep;
    $fell(busy) && !convert_start_n && !$past(convert_start_n, 8) |-> ##[0:1] asleep;
  endproperty
  property p_awake;
    $fell(busy) && convert_start_n && $past(convert_start_n, 8) |-> !asleep [*2];
  endproperty
  property p_sleep_quiet; asleep |-> !busy && !hold; endproperty
  property p_wake; $fell(asleep) |-> s_wake; endproperty
  property p_first_zero; $rose(serial_result_oe) |-> !serial_result_out; endproperty
  property p_edge;
    $changed(serial_result_out) && $past(serial_result_oe) |-> !shift_clk || !serial_result_out;
  endproperty
  property p_lsb_hold;
    $fell(serial_result_oe) |-> $past(serial_result_out) == $past(serial_result_out, 4);
  endproperty
  property p_reset_ser;
    $fell(convert_start_n) && !shift_clk |-> ##[1:8] !serial_result_oe;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("hold without busy");
  a_conv_len: assert property (p_conv_len) else $error("hold length wrong");
  a_track: assert property (p_track) else $error("no tracking at end");
  a_sleep: assert property (p_sleep) else $error("no sleep after end");
  a_awake: assert property (p_awake) else $error("slept in fast mode");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("busy while asleep");
  a_wake: assert property (p_wake) else $error("bad wake-up");
  a_first_zero: assert property (p_first_zero) else $error("first bit not zero");
  a_edge: assert property (p_edge) else $error("data moved on high clock");
  a_lsb_hold: assert property (p_lsb_hold) else $error("last bit not held");
  a_reset_ser: assert property (p_reset_ser) else $error("no serial reset");
endmodule : adc_conv_readout_monitor

bind adc_conv_readout adc_conv_readout_monitor u_mon (
  .clk              (clk),
  .rst              (rst),
  .convert_start_n  (convert_start_n),
  .shift_clk        (shift_clk),
  .busy             (busy),
  .hold             (hold),
  .asleep           (asleep),
  .serial_result_out(serial_result_out),
  .serial_result_oe (serial_result_oe)
);

// [adc_master_model.sv]
// serial master model: drives convert-start and the shift clock, captures bits
`timescale 1ns/1ps
module adc_master_model (
  input  wire logic serial_result_out,
  input  wire logic serial_result_oe,
  output logic      convert_start_n,
  output logic      shift_clk
);
  logic sclk_gen;
  logic sel;
  // shared-port style: the shift clock only reaches the converter while selected
  assign shift_clk = sclk_gen & sel;
  initial begin
    convert_start_n = 1'b1;
    sclk_gen = 1'b0;
    sel = 1'b0;
  end
  // clock stays low between pulses, so a pause is just a delay between calls
  task automatic clk_pulses(input int n, inout logic [15:0] word);
    sel = 1'b1;
    for (int i = 0; i < n; i++) begin
      #32 sclk_gen = 1'b1;
      #32 word = {word[14:0], serial_result_oe === 1'b1 ? serial_result_out : 1'bx};
      sclk_gen = 1'b0;
    end
    sel = 1'b0;
  endtask : clk_pulses
  task automatic set_start(input logic v, input int wait_ns);
    convert_start_n = v;
    #(wait_ns);
  endtask : set_start
endmodule : adc_master_model

// [test_adc_conv_readout.sv]
// self-checking bench for the conversion control and serial readout
`timescale 1ns/1ps
module test_adc_conv_readout;
  import adc_ctrl_pkg::*;
  logic                clk, rst, start_n, sclk, busy, hold, asleep, sdo, oe, slp;
  logic [RESULT_W-1:0] sample_code;
  logic [15:0]         word, e;
  int                  err_count, checked, cyc, t0;
  logic [15:0]         exp_q[$];
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end

  adc_conv_readout u_dut (.clk(clk), .rst(rst), .convert_start_n(start_n), .shift_clk(sclk),
    .sample_code(sample_code), .busy(busy), .hold(hold), .asleep(asleep),
    .serial_result_out(sdo), .serial_result_oe(oe));
  adc_master_model u_m (.serial_result_out(sdo), .serial_result_oe(oe),
    .convert_start_n(start_n), .shift_clk(sclk));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // one conversion; the code under test is fixed until the conversion ends
  task automatic conv(input logic stay_low, input int hi_ns, input int lo, input int hi);
    @(posedge clk) #1 sample_code = 12'($urandom);
    exp_q.push_back({4'h0, sample_code});
    t0 = cyc;
    if (slp) u_m.set_start(1'b1, hi_ns);
    if (slp) `CHK("hold in wake", 1'b0, hold)
    if (slp) `CHK("busy in wake", 1'b1, busy)
    u_m.set_start(1'b0, slp ? 7000 : 100);
    `CHK("hold in conv", 1'b1, hold)
    `CHK("busy in conv", 1'b1, busy)
    if (!stay_low) u_m.set_start(1'b1, 0);
    for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge clk) #1;
    `CHK("hold at end", 1'b0, hold)
    `CHK("conv cycles", 1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi))
    `CHK("asleep", stay_low, asleep)
    `CHK("oe", 1'b0, oe)
    slp = stay_low;
    e = exp_q.pop_front();
  endtask : conv
  task automatic rd(input int n1, input int n2, input logic [15:0] ex, input logic ex_oe);
    word = 16'h0000;
    u_m.clk_pulses(n1, word);
    #300;
    if (n2 > 0) u_m.clk_pulses(n2, word);
    #400;
    `CHK("frame", ex, word)
    `CHK("oe after read", ex_oe, oe)
  endtask : rd

  initial begin
    rst = 1'b1;
    slp = 1'b0;
    sample_code = 12'h000;
    err_count = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(17));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    conv(1'b0, 0, 2000, 2012);
    rd(8, 8, e, 1'b0);
    rd(16, 0, e, 1'b1);
    conv(1'b1, 0, 2000, 2012);
    rd(16, 0, e, 1'b0);
    conv(1'b1, 1000, 3500, 3515);
    rd(20, 0, {e[11:0], 4'h0}, 1'b1);
    conv(1'b1, 8000, 3995, 4015);
    rd(16, 0, e, 1'b0);
    conv(1'b0, 1000, 3500, 3515);
    rd(16, 0, e, 1'b0);
    tally_and_finish();
  end
endmodule : test_adc_conv_readout
